// ==== dual_pwm_with_period_timers.sv ====
// Purpose: two modulator channels with period timers behind AXI4-Lite
// Assumes: one clock, synchronous active-low reset
// Notes:   period match flags are sticky, cleared by writing ones
`include "pwm_consts.svh"

module dual_pwm_with_period_timers #(
  parameter int CNT_W = 10
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // modulator pins
  output logic mod_out_a,
  output logic mod_out_b
);

  pwm_pkg::ctrl_t pwm_timer_control, next_pwm_timer_control;
  logic [CNT_W-1:0] period_limit [2];
  logic [CNT_W-1:0] next_period_limit [2];
  logic [CNT_W-1:0] duty_write_value [2];
  logic [CNT_W-1:0] next_duty_write_value [2];
  logic [1:0] flag_clear;
  logic [1:0] period_match_flag;
  logic [1:0] pin;
  logic [1:0] level;
  logic wr_go, rd_go;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;

  // merges byte lanes 0 and 1 into a ten-bit field
  function automatic logic [CNT_W-1:0] lane_merge(
    input logic [CNT_W-1:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [15:0] wide;
    wide = {{(16-CNT_W){1'b0}}, old};
    if (strb[0]) wide[7:0] = data[7:0];
    if (strb[1]) wide[15:8] = data[15:8];
    return wide[CNT_W-1:0];
  endfunction

  // both write channels taken together, only while no response waits
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign rd_go = s_axi_arvalid && !rvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign mod_out_a = pin[0];
  assign mod_out_b = pin[1];

  always_comb begin
    next_pwm_timer_control = pwm_timer_control;
    next_period_limit = period_limit;
    next_duty_write_value = duty_write_value;
    flag_clear = 2'b00;
    next_bvalid = bvalid && !s_axi_bready;
    next_bresp = bresp;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      case (s_axi_awaddr)
        `OFS_CONTROL: begin
          if (s_axi_wstrb[0]) begin
            next_pwm_timer_control = s_axi_wdata[7:0];
          end
        end
        `OFS_PERIOD_A: begin
          next_period_limit[0] = lane_merge(period_limit[0], s_axi_wdata,
            s_axi_wstrb);
        end
        `OFS_PERIOD_B: begin
          next_period_limit[1] = lane_merge(period_limit[1], s_axi_wdata,
            s_axi_wstrb);
        end
        `OFS_DUTY_A: begin
          // free to write mid period; only the shadow drives the pin
          next_duty_write_value[0] = lane_merge(duty_write_value[0],
            s_axi_wdata, s_axi_wstrb);
        end
        `OFS_DUTY_B: begin
          next_duty_write_value[1] = lane_merge(duty_write_value[1],
            s_axi_wdata, s_axi_wstrb);
        end
        `OFS_STATUS: begin
          if (s_axi_wstrb[0]) begin
            flag_clear = s_axi_wdata[1:0];
          end
        end
        default: begin
          next_bresp = `RESP_SLVERR;
        end
      endcase
    end
  end

  always_comb begin
    next_rvalid = rvalid && !s_axi_rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `OFS_CONTROL: next_rdata[7:0] = pwm_timer_control;
        `OFS_PERIOD_A: next_rdata[CNT_W-1:0] = period_limit[0];
        `OFS_PERIOD_B: next_rdata[CNT_W-1:0] = period_limit[1];
        `OFS_DUTY_A: next_rdata[CNT_W-1:0] = duty_write_value[0];
        `OFS_DUTY_B: next_rdata[CNT_W-1:0] = duty_write_value[1];
        `OFS_STATUS: next_rdata[3:0] = {level, period_match_flag};
        default: next_rresp = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_timer_control <= `RST_CONTROL;
      period_limit <= '{`RST_LIMIT, `RST_LIMIT};
      duty_write_value <= '{`RST_DUTY, `RST_DUTY};
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      pwm_timer_control <= next_pwm_timer_control;
      period_limit <= next_period_limit;
      duty_write_value <= next_duty_write_value;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // one identical channel per pin
  for (genvar g = 0; g < 2; g++) begin : g_chan
    logic run, oen, tick, match;
    pwm_pkg::div_sel_t sel;
    logic [7:0] tc;
    logic [7:0] pre, next_pre;
    logic [CNT_W-1:0] period_counter, next_period_counter;
    logic [CNT_W-1:0] duty_shadow_latch, next_duty_shadow_latch;
    logic next_level, next_flag, next_pin;

    always_comb begin
      if (g == 0) begin
        run = pwm_timer_control.timer_a_run;
        oen = pwm_timer_control.out_a_enable;
        sel = pwm_pkg::div_sel_t'({pwm_timer_control.timer_a_div_hi,
          pwm_timer_control.timer_a_div_lo});
      end else begin
        run = pwm_timer_control.timer_b_run;
        oen = pwm_timer_control.out_b_enable;
        sel = pwm_pkg::div_sel_t'({pwm_timer_control.timer_b_div_hi,
          pwm_timer_control.timer_b_div_lo});
      end
      case (sel)
        pwm_pkg::DIV2: tc = `PRE_TC_DIV2;
        pwm_pkg::DIV8: tc = `PRE_TC_DIV8;
        pwm_pkg::DIV32: tc = `PRE_TC_DIV32;
        pwm_pkg::DIV64: tc = `PRE_TC_DIV64;
        default: tc = `PRE_TC_DIV2;
      endcase
      // >= guards a ratio lowered while the prescaler is above it
      tick = run && (pre >= tc);
      next_pre = (run && !tick) ? pre + 8'h01 : 8'h00;
      next_period_counter = period_counter;
      next_duty_shadow_latch = duty_shadow_latch;
      next_level = level[g];
      match = 1'b0;
      if (!run) begin
        next_level = 1'b0;
      end else if (tick) begin
        if (period_counter == period_limit[g]) begin
          next_period_counter = '0;
          next_duty_shadow_latch = duty_write_value[g];
          next_level = (duty_write_value[g] != '0);
          match = 1'b1;
        end else begin
          next_period_counter = period_counter + 1'b1;
          if (period_counter + 1'b1 == duty_shadow_latch) begin
            next_level = 1'b0;
          end
        end
      end
      // set wins over a clear in the same cycle
      next_flag = match || (period_match_flag[g] && !flag_clear[g]);
      next_pin = next_level && oen;
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pre <= 8'h00;
        period_counter <= '0;
        duty_shadow_latch <= `RST_DUTY;
        level[g] <= 1'b0;
        period_match_flag[g] <= 1'b0;
        pin[g] <= 1'b0;
      end else begin
        pre <= next_pre;
        period_counter <= next_period_counter;
        duty_shadow_latch <= next_duty_shadow_latch;
        level[g] <= next_level;
        period_match_flag[g] <= next_flag;
        pin[g] <= next_pin;
      end
    end
  end

endmodule

// ==== pwm_consts.svh ====
// Purpose: offsets, reset values, prescaler counts and responses for the
//          dual modulator block
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   definitions only
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_PERIOD_A 8'h04
`define OFS_DUTY_A 8'h08
`define OFS_PERIOD_B 8'h0c
`define OFS_DUTY_B 8'h10
`define OFS_STATUS 8'h14

// reset values
`define RST_CONTROL 8'h00
`define RST_LIMIT 10'h3ff
`define RST_DUTY 10'h000

// prescaler terminal counts: 4 system clocks times the ratio, minus one
`define PRE_TC_DIV2 8'h07
`define PRE_TC_DIV8 8'h1f
`define PRE_TC_DIV32 8'h7f
`define PRE_TC_DIV64 8'hff

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== pwm_load.sv ====
// Purpose: load on one modulator pin, measuring period and high time
// Assumes: pin is registered on the rising clock edge
// Notes:   a period is only known from the second rising edge on
module pwm_load (
  // clock and reset
  input wire logic aclk,
  input wire logic rst_n,
  // pin
  input wire logic pin,
  // measurements
  output int rises,
  output int per,
  output int hi
);
  int cyc = 0;
  int last = 0;
  logic prev = 1'b0;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prev <= pin;
    if (!rst_n) begin
      rises <= 0;
      per <= 0;
      hi <= 0;
    end else if (pin && !prev) begin
      rises <= rises + 1;
      per <= cyc - last;
      last <= cyc;
    end else if (!pin && prev) begin
      hi <= cyc - last;
    end
  end
endmodule

// ==== pwm_pkg.sv ====
// Purpose: types shared by the dual modulator block
// Assumes: nothing beyond the header of constants
// Notes:   control field order matches the register bit order
package pwm_pkg;

  typedef struct packed {
    logic out_b_enable;
    logic out_a_enable;
    logic timer_b_run;
    logic timer_a_run;
    logic timer_b_div_hi;
    logic timer_b_div_lo;
    logic timer_a_div_hi;
    logic timer_a_div_lo;
  } ctrl_t;

  typedef enum logic [1:0] {
    DIV2 = 2'b00,
    DIV8 = 2'b01,
    DIV32 = 2'b10,
    DIV64 = 2'b11
  } div_sel_t;

endpackage

// ==== pwm_sva.sv ====
// Purpose: bus handshake and pin pulse checks for the modulator block
// Assumes: one clock, synchronous active-low reset
// Notes:   pin pulses are checked to stay high at least 8 clocks, one counter step at DIV2
module pwm_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic mod_out_a,
  input wire logic mod_out_b
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_take_write: assert property (s_axi_awvalid && s_axi_wvalid &&
    !s_axi_bvalid |=> s_axi_bvalid) else $error("write not answered");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid stuck");
  a_awready_ties: assert property (s_axi_awready == (s_axi_awvalid &&
    s_axi_wvalid && !s_axi_bvalid)) else $error("awready wrong");
  a_wready_ties: assert property (s_axi_wready == s_axi_awready)
    else $error("wready wrong");
  a_take_read: assert property (s_axi_arvalid && !s_axi_rvalid |=>
    s_axi_rvalid) else $error("read not answered");
  a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid) else $error("rvalid dropped");
  a_arready_ties: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  a_pulse_a_min: assert property (
    $rose(mod_out_a) |-> mod_out_a [*8]) else $error("pin a pulse short");
  a_pulse_b_min: assert property (
    $rose(mod_out_b) |-> mod_out_b [*8]) else $error("pin b pulse short");
endmodule

// ==== tb_dual_pwm_with_period_timers.sv ====
// Purpose: register and pin timing tests of the modulator block
// Assumes: full write strobes; ready held high except one late-ready test
// Notes:   each pin test starts from reset; a pulse that the reset cuts short is not checked, as the checks are disabled in reset
`include "pwm_consts.svh"
module tb_dual_pwm_with_period_timers;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, mod_out_a, mod_out_b;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int failures = 0;
  int compares = 0;
  int rises[2], per[2], hi[2];
  int st[4] = '{8, 32, 128, 256};

  dual_pwm_with_period_timers dual_pwm_with_period_timers_i (.aclk,
    .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mod_out_a,
    .mod_out_b);
  pwm_load load_a (.aclk, .rst_n(aresetn), .pin(mod_out_a),
    .rises(rises[0]), .per(per[0]), .hi(hi[0]));
  pwm_load load_b (.aclk, .rst_n(aresetn), .pin(mod_out_b),
    .rises(rises[1]), .per(per[1]), .hi(hi[1]));

  task automatic chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s: %h vs %h", $time, m, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!(s_axi_bvalid && s_axi_bready));
    chk(s_axi_bresp, er, "bresp");
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er = `RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!(s_axi_rvalid && s_axi_rready));
    rv = s_axi_rdata;
    chk(s_axi_rresp, er, "rresp");
  endtask
  // one channel from reset: limit, duty, then prescale with enables
  task automatic pwm(input int ch, input logic [1:0] c,
                     input logic [9:0] l, d);
    rst;
    wr(ch ? `OFS_PERIOD_B : `OFS_PERIOD_A, {22'h0, l});
    wr(ch ? `OFS_DUTY_B : `OFS_DUTY_A, {22'h0, d});
    wr(`OFS_CONTROL, ch ? {24'h0, 4'ha, c, 2'b00} : {24'h0, 4'h5, 2'b00, c});
    repeat (4 * (l + 1) * st[c]) @(posedge aclk);
    if (d != 0) chk(per[ch], (l + 1) * st[c], "period");
    chk(hi[ch], d * st[c], "high time");
    chk(rises[!ch], 0, "other pin");
    rd(`OFS_STATUS);
    chk(rv[ch], 1'b1, "flag");
  endtask

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    close_out;
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'b000;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} <= 6'h3f;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0;
    rst;
    wr(`OFS_CONTROL, 32'hff);
    rst;
    rd(`OFS_CONTROL);
    chk(rv, `RST_CONTROL, "control reset");
    rd(`OFS_PERIOD_A);
    chk(rv, `RST_LIMIT, "limit reset");
    rd(`OFS_DUTY_B);
    chk(rv, `RST_DUTY, "duty reset");
    rd(8'h18, `RESP_SLVERR);
    chk(rv, 32'h0, "unmapped read");
    wr(8'h18, 32'h1, `RESP_SLVERR);
    wr(`OFS_CONTROL, 32'h1b);
    rd(`OFS_CONTROL);
    chk(rv, 32'h1b, "control fields");
    // responses must stand while the master holds its ready low
    {s_axi_bready, s_axi_rready} <= 2'b00;
    fork
      wr(`OFS_DUTY_B, 32'h3c5);
      rd(`OFS_PERIOD_B);
      begin
        repeat (4) @(posedge aclk);
        {s_axi_bready, s_axi_rready} <= 2'b11;
      end
    join
    chk(rv, `RST_LIMIT, "late ready read");
    rd(`OFS_DUTY_B);
    chk(rv, 32'h3c5, "late ready write");
    $display("registers done");
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 4; c++) begin
        pwm(ch, c[1:0], 10'h1, 10'h1);
      end
    end
    $display("prescale codes done");
    pwm(0, 2'b00, 10'h3, 10'h1);
    wr(`OFS_DUTY_A, 32'h3);
    // write lands in a high phase; old duty must still end it
    repeat (8) @(posedge aclk);
    chk(mod_out_a, 1'b0, "duty held mid period");
    repeat (88) @(posedge aclk);
    chk(hi[0], 24, "new duty");
    pwm(1, 2'b00, 10'h2, 10'h0);
    chk(rises[1], 0, "zero duty");
    $display("duty done");
    rst;
    wr(`OFS_PERIOD_A, 32'h1);
    wr(`OFS_CONTROL, 32'h10);
    repeat (64) @(posedge aclk);
    chk(rises[0], 0, "bare timer pin");
    rd(`OFS_STATUS);
    chk(rv[0], 1'b1, "bare timer flag");
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_STATUS, 32'h1);
    rd(`OFS_STATUS);
    chk(rv[1:0], 2'b00, "flag clear");
    wr(`OFS_DUTY_A, 32'h1);
    wr(`OFS_CONTROL, 32'h40);
    repeat (64) @(posedge aclk);
    chk(rises[0], 0, "stopped pin");
    rd(`OFS_STATUS);
    chk(rv[1:0], 2'b00, "stopped flag");
    $display("timer done");
    close_out;
  end
endmodule

bind dual_pwm_with_period_timers pwm_sva pwm_sva_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .mod_out_a, .mod_out_b);
